// file: rtl/i2cmra_pkg.sv
// Package: constants and types for the register-access two-wire master
package i2cmra_pkg;
  // System clock and bus rate
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned BUS_HZ = 380000;
  // Quarter-bit period in system cycles, rounded down so the bus is not slower
  localparam int unsigned QTR_CYC = CLK_HZ / (BUS_HZ * 4);
  localparam logic [7:0] QTR_CYC_W = 8'(QTR_CYC);
  // Bits per byte and the acknowledge slot
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // Direction flag values
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Controller states
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_ADDR_W, ST_REG, ST_WDATA,
    ST_RSTART, ST_ADDR_R, ST_RDATA, ST_STOP
  } i2cmra_state_e;
endpackage

// file: rtl/i2cmra_fifo_if.sv
// Interface: valid/ready stream between the FIFO and the controller
`timescale 1ns/1ns
`default_nettype none
interface i2cmra_fifo_if #(parameter int W = 8);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, output in_ready, input in_data,
                output out_valid, input out_ready, output out_data);
  modport src (output in_valid, input in_ready, output in_data);
  modport snk (input out_valid, output out_ready, input out_data);
endinterface
`default_nettype wire

// file: rtl/i2cmra_fifo.sv
// Synchronous FIFO with registered read data, valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module i2cmra_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  i2cmra_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } i2cmra_fst_s;
  i2cmra_fst_s st_reg, st_next;
  logic [W-1:0] mem [DEPTH];
  logic wr, rd, load;
  logic full; // Array plus output register hold DEPTH words
  // Handshake decode
  always_comb begin
    // Count the word parked in the output register as well
    full = ((st_reg.cnt + (AW+1)'(st_reg.ov)) == (AW+1)'(DEPTH));
    wr = f.in_valid && !full;
    rd = f.out_ready && st_reg.ov;
    // Refill the output register when it empties or is consumed
    load = (!st_reg.ov || rd) && (st_reg.cnt != '0);
    st_next = st_reg;
    if (wr) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (load) begin
      st_next.rp = st_reg.rp + 1'b1;
      st_next.od = mem[st_reg.rp];
      st_next.ov = 1'b1;
    end else if (rd) begin
      st_next.ov = 1'b0;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(wr) - (AW+1)'(load);
  end
  // Storage array
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[st_reg.wp] <= f.in_data;
    end
  end
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign f.in_ready = !full;
  assign f.out_valid = st_reg.ov;
  assign f.out_data = st_reg.od;
endmodule
`default_nettype wire

// file: rtl/i2cmra_top.sv
// Two-wire bus master doing register-addressed writes and reads
`timescale 1ns/1ns
`default_nettype none
module i2cmra_top #(
  parameter int FIFO_DEPTH = 16,
  parameter int LEN_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  // Command: pulse cmd_go while idle
  input wire logic cmd_go,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_regnum,
  input wire logic [LEN_W-1:0] cmd_len,
  // Write data stream into the FIFO
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  // Read data out
  output logic rd_valid,
  output logic [7:0] rd_data,
  // Status
  output logic busy,
  output logic done,
  output logic nack,
  // Open-drain pins, enable low while pulling the line low
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  // Reset release synchroniser
  // Asserts at once, releases two edges later for a clean exit
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Data line input through two flops; clock input only observed, no stretching wait
  // Both reset to the released level so no false start follows reset
  logic [1:0] sda_sync_reg;
  logic [1:0] scl_sync_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_sync_reg <= 2'b11;
      scl_sync_reg <= 2'b11;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
    end
  end
  logic sda_s;
  assign sda_s = sda_sync_reg[1];

  // Write data buffer
  i2cmra_fifo_if #(.W(8)) fq ();
  assign fq.in_valid = wr_valid;
  assign fq.in_data = wr_data;
  i2cmra_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .f(fq)
  );

  // Whole controller state
  typedef struct packed {
    // Sequencer
    i2cmra_pkg::i2cmra_state_e st; // Controller state
    logic [7:0] qcnt; // Quarter-bit down counter
    logic [1:0] phase; // Quarter within a bit
    logic [3:0] bitn; // Bit index, 8 is the ack slot
    // Byte shifter and command copy
    logic [7:0] sh; // Shift register, MSB out first
    logic rd; // Read transaction
    logic [6:0] addr; // Slave address
    logic [7:0] regn; // Register number
    logic [LEN_W-1:0] left; // Data bytes still to move
    // Pin drive, low enable pulls the line
    logic scl;
    logic sda;
    // Registered outputs
    logic rdv;
    logic [7:0] rdd;
    logic busy;
    logic done;
    logic nack;
    logic wrdy;
    logic pop; // Consume the FIFO head
  } i2cmra_st_s;
  i2cmra_st_s s_reg, s_next;

  // Quarter-bit tick
  // One pulse per quarter bit, the only slower rate in the block
  logic tick;
  assign tick = (s_reg.qcnt == '0);

  // Address byte assembly
  function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic dir);
    addr_byte = {a, dir};
  endfunction

  assign fq.out_ready = s_reg.pop;

  // Next-state logic
  always_comb begin
    s_next = s_reg;
    // One-cycle pulses default low
    s_next.rdv = 1'b0;
    s_next.done = 1'b0;
    s_next.pop = 1'b0;
    s_next.wrdy = fq.in_ready;
    // Divider towards the bus rate
    s_next.qcnt = tick ? i2cmra_pkg::QTR_CYC_W - 8'h01 : s_reg.qcnt - 8'h01;
    unique case (s_reg.st)
      i2cmra_pkg::ST_IDLE: begin
        // Bus released, wait for a command
        s_next.scl = 1'b1;
        s_next.sda = 1'b1;
        s_next.phase = 2'h0;
        if (cmd_go) begin
          // Latch the command; zero length counts as one byte
          s_next.st = i2cmra_pkg::ST_START;
          s_next.rd = cmd_read;
          s_next.addr = cmd_addr;
          s_next.regn = cmd_regnum;
          s_next.left = (cmd_len == '0) ? LEN_W'(1) : cmd_len;
          s_next.busy = 1'b1;
          s_next.nack = 1'b0;
          s_next.qcnt = i2cmra_pkg::QTR_CYC_W - 8'h01;
        end
      end
      i2cmra_pkg::ST_START, i2cmra_pkg::ST_RSTART: begin
        // Phases: release data, raise clock, pull data, pull clock
        if (tick) begin
          s_next.phase = s_reg.phase + 2'h1;
          unique case (s_reg.phase)
            2'h0: s_next.sda = 1'b1;
            2'h1: s_next.scl = 1'b1;
            2'h2: s_next.sda = 1'b0;
            2'h3: begin
              // Clock low: load the address byte with its direction
              s_next.scl = 1'b0;
              s_next.bitn = 4'h0;
              s_next.sh = (s_reg.st == i2cmra_pkg::ST_RSTART) ?
                addr_byte(s_reg.addr, i2cmra_pkg::DIR_READ) :
                addr_byte(s_reg.addr, i2cmra_pkg::DIR_WRITE);
              s_next.st = (s_reg.st == i2cmra_pkg::ST_RSTART) ?
                i2cmra_pkg::ST_ADDR_R : i2cmra_pkg::ST_ADDR_W;
            end
          endcase
        end
      end
      i2cmra_pkg::ST_STOP: begin
        // Phases: pull data, raise clock, release data, finish
        if (tick) begin
          s_next.phase = s_reg.phase + 2'h1;
          unique case (s_reg.phase)
            2'h0: s_next.sda = 1'b0;
            2'h1: s_next.scl = 1'b1;
            2'h2: s_next.sda = 1'b1;
            2'h3: begin
              s_next.st = i2cmra_pkg::ST_IDLE;
              s_next.busy = 1'b0;
              s_next.done = 1'b1;
            end
          endcase
        end
      end
      default: begin
        // Byte engine: nine clocks, phase 0 set data, 1 raise, 2 sample, 3 lower
        if (tick) begin
          s_next.phase = s_reg.phase + 2'h1;
          unique case (s_reg.phase)
            2'h0: begin
              if (s_reg.bitn == i2cmra_pkg::ACK_SLOT) begin
                // Receiver acks a written byte; master acks reads, last one high
                s_next.sda = (s_reg.st == i2cmra_pkg::ST_RDATA) ?
                  (s_reg.left == LEN_W'(1)) : 1'b1;
              end else begin
                s_next.sda = (s_reg.st == i2cmra_pkg::ST_RDATA) ? 1'b1 : s_reg.sh[7];
              end
            end
            2'h1: s_next.scl = 1'b1;
            2'h2: begin
              // Clock not checked for stretching
              if (s_reg.bitn != i2cmra_pkg::ACK_SLOT) begin
                s_next.sh = {s_reg.sh[6:0], sda_s};
              end else if (s_reg.st != i2cmra_pkg::ST_RDATA && sda_s) begin
                s_next.nack = 1'b1;
              end
            end
            2'h3: begin
              // Clock low: next bit, or decide after the ack slot
              s_next.scl = 1'b0;
              s_next.bitn = s_reg.bitn + 4'h1;
              if (s_reg.bitn == i2cmra_pkg::ACK_SLOT) begin
                s_next.bitn = 4'h0;
                if (s_reg.nack) begin
                  s_next.st = i2cmra_pkg::ST_STOP;
                end else begin
                  unique case (s_reg.st)
                    i2cmra_pkg::ST_ADDR_W: begin
                      s_next.st = i2cmra_pkg::ST_REG;
                      s_next.sh = s_reg.regn;
                    end
                    i2cmra_pkg::ST_REG: begin
                      // Read turns round; write needs a buffered byte
                      if (s_reg.rd) begin
                        s_next.st = i2cmra_pkg::ST_RSTART;
                      end else if (fq.out_valid) begin
                        s_next.st = i2cmra_pkg::ST_WDATA;
                        s_next.sh = fq.out_data;
                        s_next.pop = 1'b1;
                      end else begin
                        s_next.st = i2cmra_pkg::ST_STOP;
                      end
                    end
                    i2cmra_pkg::ST_WDATA: begin
                      // Stop after the counted bytes or when the buffer runs dry
                      if (s_reg.left == LEN_W'(1) || !fq.out_valid) begin
                        s_next.st = i2cmra_pkg::ST_STOP;
                      end else begin
                        s_next.sh = fq.out_data;
                        s_next.pop = 1'b1;
                      end
                      s_next.left = s_reg.left - LEN_W'(1);
                    end
                    i2cmra_pkg::ST_ADDR_R: begin
                      s_next.st = i2cmra_pkg::ST_RDATA;
                    end
                    default: begin
                      // Read byte complete: hand it out
                      s_next.rdv = 1'b1;
                      s_next.rdd = s_reg.sh;
                      s_next.left = s_reg.left - LEN_W'(1);
                      if (s_reg.left == LEN_W'(1)) begin
                        s_next.st = i2cmra_pkg::ST_STOP;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
    endcase
  end

  // State register
  // Reset leaves both lines released and the sequencer idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: i2cmra_pkg::ST_IDLE, scl: 1'b1, sda: 1'b1, rdd: i2cmra_pkg::BYTE_RST,
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops, except the pin data outputs tied low
  // Stream side
  assign wr_ready = s_reg.wrdy;
  assign rd_valid = s_reg.rdv;
  assign rd_data = s_reg.rdd;
  // Status
  assign busy = s_reg.busy;
  assign done = s_reg.done;
  assign nack = s_reg.nack;
  // Open drain: the pins only ever pull low
  assign scl_o = 1'b0;
  assign scl_oe_n = s_reg.scl;
  assign sda_o = 1'b0;
  assign sda_oe_n = s_reg.sda;
endmodule
`default_nettype wire

// file: testbench/i2cmra_checker.sv
// Checker: pin and status timing of the two-wire master
`timescale 1ns/1ns
`default_nettype none
module i2cmra_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_go,
  input wire logic rd_valid,
  input wire logic busy,
  input wire logic done,
  input wire logic nack,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_o,
  input wire logic sda_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [9:0] gap_reg; // Cycles since last clock release
  // Saturating gap counter between clock releases
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) gap_reg <= 10'h000;
    else if ($rose(scl_oe_n)) gap_reg <= 10'h000;
    else if (gap_reg != 10'h3ff) gap_reg <= gap_reg + 10'h001;
  end
  go_busy_a: assert property (cmd_go && !busy |=> busy && !nack)
    else $error("command not taken");
  idle_bus_a: assert property (!busy && !$past(busy) |-> scl_oe_n && sda_oe_n)
    else $error("bus held while idle");
  start_busy_a: assert property ($fell(sda_oe_n) && scl_oe_n && $past(scl_oe_n) |-> busy)
    else $error("start outside transfer");
  stop_done_a: assert property ($rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n) |-> ##[0:400] done)
    else $error("stop without done");
  done_bus_a: assert property ($rose(done) |-> scl_oe_n && sda_oe_n ##1 !done)
    else $error("done before stop");
  rd_pulse_a: assert property (rd_valid |-> busy ##1 !rd_valid)
    else $error("read pulse wrong");
  pins_low_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin driven high");
  clk_rate_a: assert property ($rose(scl_oe_n) |-> gap_reg >= 10'h12c)
    else $error("bus clock too fast");
  clk_high_a: assert property ($rose(scl_oe_n) && busy |=> scl_oe_n [*8])
    else $error("clock high too short");
  cover property (rd_valid);
  cover property (done && nack);
  cover property ($rose(done) && !nack);
endmodule
bind i2cmra_top i2cmra_checker i2cmra_checker_i (.clk(clk), .rstn(rstn), .cmd_go(cmd_go),
  .rd_valid(rd_valid), .busy(busy), .done(done), .nack(nack), .scl_o(scl_o),
  .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
`default_nettype wire

// file: testbench/i2cmra_slave.sv
// Partner model: register-addressed slave on the two-wire bus
`timescale 1ns/1ns
`default_nettype none
module i2cmra_slave #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe_n
);
  // Clock line is never touched, so no stretching
  logic [7:0] mem [256]; // Register file
  logic [7:0] sh = 8'h00; // Shift-in byte
  logic [7:0] ptr = 8'h00; // Register pointer
  logic sel = 1'b0; // Addressed
  logic rd = 1'b0; // Read phase
  logic tx = 1'b0; // Slave is sending
  logic last_mack = 1'b0; // Last master ack bit
  int bitn = 0;
  int nbyte = 0;
  int starts = 0;
  int stops = 0;
  logic [7:0] alog [$]; // Address bytes seen
  initial sda_oe_n = 1'b1;
  // Start or repeated start
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      starts++;
      bitn = -1;
      nbyte = 0;
      sel = 1'b0;
      rd = 1'b0;
      tx = 1'b0;
    end
  end
  // Stop releases everything
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      stops++;
      sel = 1'b0;
      tx = 1'b0;
      sda_oe_n = 1'b1;
    end
  end
  // Sample on clock rise
  always @(posedge scl) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (tx) begin
      last_mack = sda;
      if (sda) rd = 1'b0;
    end
  end
  // Ack, store and next bit on clock fall
  always @(negedge scl) begin
    bitn++;
    if (bitn == 8 && tx) begin
      sda_oe_n = 1'b1;
      ptr++;
    end else if (bitn == 8) begin
      if (nbyte == 0) begin
        alog.push_back(sh);
        sel = (sh[7:1] == ADDR);
        rd = sel & sh[0];
      end else if (sel && nbyte == 1) ptr = sh;
      else if (sel) begin
        mem[ptr] = sh;
        ptr++;
      end
      sda_oe_n = !sel;
    end else if (bitn == 9) begin
      bitn = 0;
      nbyte++;
      tx = rd;
      sda_oe_n = rd ? mem[ptr][7] : 1'b1;
    end else if (tx) sda_oe_n = mem[ptr][7 - bitn];
  end
endmodule
`default_nettype wire

// file: testbench/test_i2c_master_register_access.sv
// Testbench: FIFO fill, burst write, read back and a refused address
`timescale 1ns/1ns
`default_nettype none
module test_i2c_master_register_access;
  localparam logic [6:0] SA = 7'h2a; // Slave address
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_go = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_regnum = 8'h00;
  logic [7:0] cmd_len = 8'h00;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wr_ready, rd_valid, busy, done, nack, scl_o, scl_oe_n, sda_o, sda_oe_n, s_oe_n;
  logic [7:0] rd_data;
  wire scl = scl_oe_n; // Pulled up when released
  wire sda = sda_oe_n & s_oe_n;
  int err_count = 0;
  int n_tests = 0;
  int seed = 32'h1cd88fcb;
  int s0, p0, i;
  logic [7:0] r;
  logic [7:0] rq [$]; // Expected read bytes
  logic [7:0] wq [$]; // Bytes loaded into FIFO
  always #4 clk = ~clk;
  i2cmra_top i2cmra_top_i (.clk(clk), .rstn(rstn), .cmd_go(cmd_go), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_regnum(cmd_regnum), .cmd_len(cmd_len), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .busy(busy), .done(done), .nack(nack), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  i2cmra_slave #(.ADDR(SA)) i2cmra_slave_i (.scl(scl), .sda(sda), .sda_oe_n(s_oe_n));
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task wrap_up;
    $display("errors=%0d tests=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One FIFO word, then a gap so ready can settle
  task push(input logic [7:0] d);
    wr_valid = 1'b1;
    wr_data = d;
    wq.push_back(d);
    @(negedge clk);
    wr_valid = 1'b0;
    @(negedge clk);
  endtask
  // Command, a refused second go, wait for done
  task cmd(input logic rdc, input logic [6:0] a, input logic [7:0] rg, input logic [7:0] n);
    int k;
    s0 = i2cmra_slave_i.starts;
    p0 = i2cmra_slave_i.stops;
    cmd_read = rdc;
    cmd_addr = a;
    cmd_regnum = rg;
    cmd_len = n;
    cmd_go = 1'b1;
    @(negedge clk);
    cmd_go = 1'b0;
    chk(busy, 1'b1);
    repeat (20) @(negedge clk);
    cmd_go = 1'b1;
    @(negedge clk);
    cmd_go = 1'b0;
    for (k = 0; k < 70000 && done !== 1'b1; k++) @(negedge clk);
    chk(done, 1'b1);
    chk(busy, 1'b0);
  endtask
  // Read data checker
  always @(negedge clk) if (rd_valid === 1'b1) chk(rd_data, rq.pop_front());
  // Watchdog: the three transfers need about 76k cycles, allow 87.5k
  initial begin
    #700000;
    err_count++;
    wrap_up;
  end
  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    while (wr_ready === 1'b1 && wq.size() < 20) push(8'($random(seed)));
    chk(wq.size(), 16);
    r = 8'($random(seed));
    cmd(1'b0, SA, r, 8'h10);
    chk(i2cmra_slave_i.starts - s0, 1);
    chk(i2cmra_slave_i.stops - p0, 1);
    chk(i2cmra_slave_i.alog[$], {SA, 1'b0});
    for (i = 0; i < 16; i++) chk(i2cmra_slave_i.mem[r + 8'(i)], wq[i]);
    chk(nack, 1'b0);
    for (i = 3; i < 6; i++) rq.push_back(wq[i]);
    cmd(1'b1, SA, r + 8'h03, 8'h03);
    chk(i2cmra_slave_i.starts - s0, 2);
    chk(i2cmra_slave_i.stops - p0, 1);
    chk(i2cmra_slave_i.alog[$ - 1], {SA, 1'b0});
    chk(i2cmra_slave_i.alog[$], {SA, 1'b1});
    chk(i2cmra_slave_i.last_mack, 1'b1);
    chk(rq.size(), 0);
    push(8'h5a);
    cmd(1'b0, SA ^ 7'h01, 8'h00, 8'h01);
    chk(nack, 1'b1);
    chk(i2cmra_slave_i.stops - p0, 1);
    wrap_up;
  end
endmodule
`default_nettype wire
